//--- hdl/mst_regs.vh
// Constants for the microstep translator: register map, fields, reset values, timing.
// Summary of operation
// - Resolution selects decode: low-low full, lo-only half, hi-only quarter, both sixteenth.
// - Each advance rising edge moves position one increment, updating DAC levels and polarity.
// - Resolution changes take effect only at the next advance rising edge.
// - Power-on or reset loads Home into both DACs and polarities, both bridges mixed.
// - After a step, unless the off-time pin is grounded or at supply in full step, lower new DAC level selects mixed decay, else slow decay.
// - While translator reset is low, hold Home and keep every output FET off.
// - Advance edges are ignored while translator reset is low; stepping resumes afterwards.
// - Thermal or overcurrent trip returns the translator to Home, common to all modes.
// - Off-time pin grounded gives mixed decay always, with a 30 us off-time.
// - Each bridge uses fixed off-time PWM with trip level set by its DAC.
// - Rotation sense is sampled only at the advance rising edge.
// - Off-time pin at supply gives 30 us, automatic mixed decay, slow in full step.
// - Mixed decay is fast decay for 31.25% of off-time, then slow.
// - Current-sense comparator is ignored for about 1 us after each switching event.
`ifndef MST_REGS_VH
`define MST_REGS_VH

`define MST_CLK_MHZ        100
`define MST_T_OFF_US       30
`define MST_T_BLANK_US     1
`define MST_OFF_CYC        (`MST_T_OFF_US * `MST_CLK_MHZ)
`define MST_BLANK_CYC      (`MST_T_BLANK_US * `MST_CLK_MHZ)
`define MST_FAST_NUM       5
`define MST_FAST_SHIFT     4

`define MST_ADDR_STATUS    4'h0
`define MST_ADDR_LEVELS    4'h4
`define MST_ADDR_OFFTIME   4'h8
`define MST_ADDR_CTRL      4'hc

`define MST_CTRL_HOME_BIT  0
`define MST_OFFTIME_RST    12'hbb8

`define MST_HOME_POS       6'h08
`define MST_RES_FULL       2'h0
`define MST_RES_HALF       2'h1
`define MST_RES_QUARTER    2'h2
`define MST_RES_SIXTEENTH  2'h3

`define MST_OFFCFG_GND     2'h0
`define MST_OFFCFG_VDD     2'h1

`define MST_DRV_OFF        2'h0
`define MST_DRV_ON         2'h1
`define MST_DRV_FAST       2'h2
`define MST_DRV_SLOW       2'h3

`endif

//--- hdl/mst_sync.v
// Three-stage input synchroniser whose output moves once stages two and three agree.
`timescale 1ns/1ps
module mst_sync #(
    parameter W = 1
) (
    input  wire         i_clk_sys,  // System clock
    input  wire         i_rstn,     // Asynchronous reset, active low
    input  wire [W-1:0] i_async,    // Input from outside the clock domain
    output reg  [W-1:0] o_sync      // Filtered synchronous copy
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    integer     k;

    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            s1_r   <= {W{1'b0}};
            s2_r   <= {W{1'b0}};
            s3_r   <= {W{1'b0}};
            o_sync <= {W{1'b0}};
        end
        else
        begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (k = 0; k < W; k = k + 1)
            begin
                if (s2_r[k] == s3_r[k])
                    o_sync[k] <= s3_r[k];
            end
        end
    end
endmodule

//--- hdl/mst_bridge_pwm.v
// Fixed off-time PWM sequencer for one full-bridge, with blanking and mixed decay.
`timescale 1ns/1ps
`include "mst_regs.vh"
module mst_bridge_pwm (
    input  wire        i_clk_sys,  // System clock
    input  wire        i_rstn,     // Asynchronous reset, active low
    input  wire        i_hold,     // All FETs off while high
    input  wire        i_mixed,    // Mixed decay selected
    input  wire        i_trip,     // Synchronised current-sense comparator
    input  wire [11:0] i_off_cyc,  // Off-time in clock cycles
    output reg  [1:0]  o_drv       // Bridge drive state
);
    localparam [11:0] BLANK    = `MST_BLANK_CYC;
    localparam [15:0] FAST_NUM = `MST_FAST_NUM;

    reg  [11:0] cnt_r;
    wire [15:0] fast_prod = {4'h0, i_off_cyc} * FAST_NUM;
    wire [11:0] fast_raw  = fast_prod[15:4];
    wire [11:0] fast_len  = (fast_raw == 12'h000) ? 12'h001 : fast_raw;

    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_drv <= `MST_DRV_OFF;
            cnt_r <= 12'h000;
        end
        else if (i_hold)
        begin
            o_drv <= `MST_DRV_OFF;
            cnt_r <= 12'h000;
        end
        else
        begin
            case (o_drv)
                `MST_DRV_OFF:
                begin
                    o_drv <= `MST_DRV_ON;
                    cnt_r <= BLANK - 12'h001;
                end
                `MST_DRV_ON:
                begin
                    if (cnt_r != 12'h000)
                        cnt_r <= cnt_r - 12'h001;
                    else if (i_trip)
                    begin
                        o_drv <= i_mixed ? `MST_DRV_FAST : `MST_DRV_SLOW;
                        cnt_r <= (i_mixed ? fast_len : i_off_cyc) - 12'h001;
                    end
                end
                `MST_DRV_FAST:
                begin
                    if (cnt_r != 12'h000)
                        cnt_r <= cnt_r - 12'h001;
                    else
                    begin
                        o_drv <= `MST_DRV_SLOW;
                        cnt_r <= i_off_cyc - fast_len - 12'h001;
                    end
                end
                default:
                begin
                    if (cnt_r != 12'h000)
                        cnt_r <= cnt_r - 12'h001;
                    else
                    begin
                        o_drv <= `MST_DRV_ON;
                        cnt_r <= BLANK - 12'h001;
                    end
                end
            endcase
        end
    end
endmodule

//--- hdl/mst_translator.v
// Microstep translator with decay selection, two bridge PWM sequencers and registers.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "mst_regs.vh"
module mst_translator (
    input  wire        i_clk_sys,         // System clock, 100 MHz
    input  wire        i_rstn,            // Asynchronous reset, active low
    input  wire        i_step,            // Advance pulse pin
    input  wire        i_dir,             // Rotation sense pin
    input  wire        i_resolution_sel_lo, // Resolution select, low bit
    input  wire        i_resolution_sel_hi, // Resolution select, high bit
    input  wire        i_xlat_rst_n,      // Translator reset pin, active low
    input  wire [1:0]  i_offtime_config_pin, // 0 ground, 1 supply, 2/3 resistor
    input  wire        i_thermal_trip,    // Thermal shutdown trip
    input  wire        i_overcurrent_trip, // Overcurrent trip
    input  wire        i_cmp_a,           // Bridge A sense comparator
    input  wire        i_cmp_b,           // Bridge B sense comparator
    input  wire [3:0]  i_addr,            // Register byte address
    input  wire [31:0] i_wdata,           // Register write data
    input  wire        i_wr,              // Write strobe
    input  wire        i_rd,              // Read strobe
    output reg  [31:0] o_rdata,           // Read data, cycle after read
    output reg  [6:0]  o_dac_a,           // Bridge A DAC level, percent
    output reg         o_pol_a,           // Bridge A polarity, 1 positive
    output reg  [6:0]  o_dac_b,           // Bridge B DAC level, percent
    output reg         o_pol_b,           // Bridge B polarity, 1 positive
    output reg         o_mixed_a,         // Bridge A mixed decay
    output reg         o_mixed_b,         // Bridge B mixed decay
    output wire [1:0]  o_drv_a,           // Bridge A drive state
    output wire [1:0]  o_drv_b            // Bridge B drive state
);
    // Home is 45 degrees: both windings at the same level, both polarities positive.
    localparam [6:0] HOME_DAC = 7'h47;
    localparam       HOME_POL = 1'b1;

    // Synchronised pin levels, packed for one synchroniser instance.
    wire [10:0] pins_s;
    wire        step_s  = pins_s[0];
    wire        dir_s   = pins_s[1];
    wire [1:0]  ms_s    = {pins_s[3], pins_s[2]};
    wire        xrstn_s = pins_s[4];
    wire [1:0]  ocfg_s  = pins_s[6:5];
    wire        fault_s = pins_s[7] | pins_s[8];
    wire        cmpa_s  = pins_s[9];
    wire        cmpb_s  = pins_s[10];

    reg         step_d_r;
    reg  [5:0]  pos_r;
    reg  [1:0]  res_r;
    reg         held_r;
    reg         soft_home_r;
    reg  [11:0] offtime_r;
    reg  [5:0]  pos_nxt;
    reg  [5:0]  inc_nxt;
    reg  [6:0]  lvla_nxt;
    reg  [6:0]  lvlb_nxt;
    reg         pola_nxt;
    reg         polb_nxt;
    reg         mixa_nxt;
    reg         mixb_nxt;
    reg  [1:0]  res_nxt;
    reg  [31:0] rdata_nxt;

    // Any of the three home sources holds the translator; the bridges follow one
    // cycle later through held_r, so the FET-off decision comes from a flop.
    wire        hold = ~xrstn_s | fault_s | soft_home_r;
    wire        step_edge = step_s & ~step_d_r;
    wire [11:0] off_cyc;
    wire [11:0] off_eff;
    wire [10:0] pins_raw;

    // Pin order on the synchroniser; the unpacking above must follow it.
    assign pins_raw[0]   = i_step;
    assign pins_raw[1]   = i_dir;
    assign pins_raw[2]   = i_resolution_sel_lo;
    assign pins_raw[3]   = i_resolution_sel_hi;
    assign pins_raw[4]   = i_xlat_rst_n;
    assign pins_raw[6:5] = i_offtime_config_pin;
    assign pins_raw[7]   = i_thermal_trip;
    assign pins_raw[8]   = i_overcurrent_trip;
    assign pins_raw[9]   = i_cmp_a;
    assign pins_raw[10]  = i_cmp_b;

    mst_sync #(
        .W (11)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_async   (pins_raw),
        .o_sync    (pins_s)
    );

    // Quarter-wave table, 17 points from 0 to 90 degrees, in percent of full trip.
    function [6:0] wave;
        input [4:0] idx;
        begin
            case (idx)
                5'h00:   wave = 7'h00;
                5'h01:   wave = 7'h0a;
                5'h02:   wave = 7'h14;
                5'h03:   wave = 7'h1d;
                5'h04:   wave = 7'h26;
                5'h05:   wave = 7'h2f;
                5'h06:   wave = 7'h38;
                5'h07:   wave = 7'h3f;
                5'h08:   wave = 7'h47;
                5'h09:   wave = 7'h4d;
                5'h0a:   wave = 7'h53;
                5'h0b:   wave = 7'h58;
                5'h0c:   wave = 7'h5c;
                5'h0d:   wave = 7'h60;
                5'h0e:   wave = 7'h62;
                5'h0f:   wave = 7'h64;
                default: wave = 7'h64;
            endcase
        end
    endfunction

    // Sine-side table index for a position; the cosine side uses 16 minus it.
    function [4:0] sin_idx;
        input [5:0] p;
        begin
            if (p[4])
                sin_idx = 5'h10 - {1'b0, p[3:0]};
            else
                sin_idx = {1'b0, p[3:0]};
        end
    endfunction

    // A register value below four would leave no room for the fast and slow parts of
    // the off-time, so the bridges never see less than four cycles.
    assign off_eff = (offtime_r < 12'h004) ? 12'h004 : offtime_r;

    // Ground strap runs at the fixed 30 us; the supply strap too; otherwise software sets it.
    assign off_cyc = (ocfg_s == `MST_OFFCFG_GND || ocfg_s == `MST_OFFCFG_VDD)
                     ? `MST_OFFTIME_RST : off_eff;

    always @*
    begin
        res_nxt = ms_s;
        case (ms_s)
            `MST_RES_FULL:    inc_nxt = 6'h10;
            `MST_RES_HALF:    inc_nxt = 6'h08;
            `MST_RES_QUARTER: inc_nxt = 6'h04;
            default:          inc_nxt = 6'h01;
        endcase
        if (dir_s)
            pos_nxt = pos_r + inc_nxt;
        else
            pos_nxt = pos_r - inc_nxt;
        lvla_nxt = wave(sin_idx(pos_nxt));
        lvlb_nxt = wave(5'h10 - sin_idx(pos_nxt));
        pola_nxt = ~pos_nxt[5];
        polb_nxt = (pos_nxt[5:4] == 2'h0) || (pos_nxt[5:4] == 2'h3);
        // Falling level gives mixed
        // The compare uses the level driven now, before this step loads the new one.
        mixa_nxt = (lvla_nxt < o_dac_a);
        mixb_nxt = (lvlb_nxt < o_dac_b);
        if (ocfg_s == `MST_OFFCFG_GND)
        begin
            mixa_nxt = 1'b1;
            mixb_nxt = 1'b1;
        end
        else if (ocfg_s == `MST_OFFCFG_VDD && ms_s == `MST_RES_FULL)
        begin
            mixa_nxt = 1'b0;
            mixb_nxt = 1'b0;
        end
    end

    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pos_r     <= `MST_HOME_POS;
            res_r     <= `MST_RES_FULL;
            o_dac_a   <= HOME_DAC;
            o_dac_b   <= HOME_DAC;
            o_pol_a   <= HOME_POL;
            o_pol_b   <= HOME_POL;
            o_mixed_a <= 1'b1;
            o_mixed_b <= 1'b1;
        end
        else
        begin
            if (hold)
            begin
                pos_r     <= `MST_HOME_POS;
                o_dac_a   <= HOME_DAC;
                o_dac_b   <= HOME_DAC;
                o_pol_a   <= HOME_POL;
                o_pol_b   <= HOME_POL;
                o_mixed_a <= 1'b1;
                o_mixed_b <= 1'b1;
            end
            else if (step_edge)
            begin
                pos_r     <= pos_nxt;
                res_r     <= res_nxt;
                o_dac_a   <= lvla_nxt;
                o_dac_b   <= lvlb_nxt;
                o_pol_a   <= pola_nxt;
                o_pol_b   <= polb_nxt;
                o_mixed_a <= mixa_nxt;
                o_mixed_b <= mixb_nxt;
            end
        end
    end

    // Edge history tracks the pin even while held, so release makes no false edge.
    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            step_d_r <= 1'b0;
            held_r   <= 1'b1;
        end
        else
        begin
            step_d_r <= step_s;
            held_r   <= hold;
        end
    end

    mst_bridge_pwm u_bridge_a (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_hold    (held_r),
        .i_mixed   (o_mixed_a),
        .i_trip    (cmpa_s),
        .i_off_cyc (off_cyc),
        .o_drv     (o_drv_a)
    );

    mst_bridge_pwm u_bridge_b (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_hold    (held_r),
        .i_mixed   (o_mixed_b),
        .i_trip    (cmpb_s),
        .i_off_cyc (off_cyc),
        .o_drv     (o_drv_b)
    );

    // Register write side. The home request is a one-cycle pulse, so it clears itself.
    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            offtime_r   <= `MST_OFFTIME_RST;
            soft_home_r <= 1'b0;
        end
        else
        begin
            soft_home_r <= i_wr && (i_addr == `MST_ADDR_CTRL)
                           && i_wdata[`MST_CTRL_HOME_BIT];
            if (i_wr && i_addr == `MST_ADDR_OFFTIME)
                offtime_r <= i_wdata[11:0];
        end
    end

    always @*
    begin
        rdata_nxt = 32'h0000_0000;
        if (i_rd)
        begin
            case (i_addr)
                `MST_ADDR_STATUS:
                    rdata_nxt = {21'h000000, o_mixed_b, o_mixed_a, held_r, res_r, pos_r};
                `MST_ADDR_LEVELS:
                    rdata_nxt = {16'h0000, o_pol_b, o_dac_b, o_pol_a, o_dac_a};
                `MST_ADDR_OFFTIME:
                    rdata_nxt = {20'h00000, offtime_r};
                // Control is write-only; its home bit is a pulse and reads back as zero.
                `MST_ADDR_CTRL:
                    rdata_nxt = 32'h0000_0000;
                default:
                    rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Read data stand for one cycle only and are zero otherwise.
    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            o_rdata <= 32'h0000_0000;
        else
            o_rdata <= rdata_nxt;
    end
endmodule

//--- testbench/mst_step_src.sv
// Controller model that issues advance pulses with legal widths.
`timescale 1ns/1ps
module mst_step_src (
    input  wire logic       i_clk_sys, // Clock
    input  wire logic       i_go,      // Start one pulse
    input  wire logic       i_dir,     // Rotation sense to present
    input  wire logic [1:0] i_res,     // Resolution to present
    output logic            o_step,    // Advance pulse
    output logic            o_dir,     // Rotation sense pin
    output logic [1:0]      o_sel,     // Resolution pins, hi then lo
    output logic            o_busy     // Pulse in progress
);
    int cnt;
    initial
    begin
        {o_step, o_dir, o_sel, o_busy} = 5'h00;
        cnt = 0;
    end
    always @(posedge i_clk_sys)
    begin
        o_dir <= i_dir;
        o_sel <= i_res;
        if (o_busy)
        begin
            cnt <= cnt + 1;
            o_step <= cnt >= 9 && cnt < 109;
            o_busy <= cnt < 209;
        end
        else if (i_go)
        begin
            o_busy <= 1'b1;
            cnt <= 0;
        end
    end
endmodule

//--- testbench/mst_chk.sv
// Checker of the translator port behaviour.
`timescale 1ns/1ps
module mst_chk (
    input wire logic        i_clk_sys, i_rstn, i_step, i_xlat_rst_n,
    input wire logic        i_resolution_sel_lo, i_resolution_sel_hi,
    input wire logic        i_thermal_trip, i_overcurrent_trip, i_wr, i_rd,
    input wire logic [1:0]  i_offtime_config_pin,
    input wire logic [3:0]  i_addr,
    input wire logic [31:0] o_rdata,
    input wire logic [6:0]  o_dac_a, o_dac_b,
    input wire logic        o_pol_a, o_pol_b, o_mixed_a, o_mixed_b,
    input wire logic [1:0]  o_drv_a, o_drv_b
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    logic [15:0] lev;
    logic [3:0]  qcnt;
    logic [1:0]  pin_q;
    logic        quiet;
    logic        home;
    assign lev = {o_pol_b, o_dac_b, o_pol_a, o_dac_a};
    assign quiet = qcnt >= 4'ha;
    assign home = lev == 16'hc7c7 && o_mixed_a && o_mixed_b;
    // Home commands move levels by themselves and strap changes reach the translator late, so wait them out.
    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            qcnt <= 4'h0;
            pin_q <= 2'h0;
        end
        else
        begin
            pin_q <= i_offtime_config_pin;
            if (!i_xlat_rst_n || i_thermal_trip || i_overcurrent_trip
                || (i_wr && i_addr == 4'hc) || pin_q != i_offtime_config_pin)
                qcnt <= 4'h0;
            else if (!quiet)
                qcnt <= qcnt + 4'h1;
        end
    end
    hold_home_a: assert property ((!i_xlat_rst_n) [*7] |-> home)
        else $error("levels not at home while reset held");
    fets_off_a: assert property ((!i_xlat_rst_n) [*8] |-> o_drv_a == 2'h0 && o_drv_b == 2'h0)
        else $error("bridge driving while reset held");
    trip_home_a: assert property ((i_thermal_trip || i_overcurrent_trip) [*7] |-> home)
        else $error("levels not at home during trip");
    step_time_a:
        assert property (quiet && $rose(i_step) |-> ##4 $stable(lev) ##1 !$stable(lev))
        else $error("levels did not move five cycles after advance");
    step_only_a:
        assert property (quiet && $changed(lev) |-> $past(i_step, 5) && !$past(i_step, 6))
        else $error("levels moved without an advance edge");
    auto_decay_a: assert property (quiet && i_offtime_config_pin == 2'h2 && $changed(lev)
        |-> o_mixed_a == (o_dac_a < $past(o_dac_a)) && o_mixed_b == (o_dac_b < $past(o_dac_b)))
        else $error("automatic decay choice wrong");
    ground_mixed_a: assert property (quiet && i_offtime_config_pin == 2'h0 && $changed(lev)
        |-> o_mixed_a && o_mixed_b)
        else $error("grounded strap not mixed");
    full_slow_a: assert property (quiet && i_offtime_config_pin == 2'h1 && $changed(lev)
        && !$past(i_resolution_sel_lo, 5) && !$past(i_resolution_sel_hi, 5)
        |-> !o_mixed_a && !o_mixed_b)
        else $error("full step on supply strap not slow");
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside read cycle");
endmodule
bind mst_translator mst_chk u_chk (.*);

//--- testbench/tb_top.sv
// Self-checking testbench for the microstep translator.
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, rstn = 0, go = 0, dir = 0, xrst_n = 1, thermal = 0, ovc = 0;
    logic cmp = 0, wr = 0, rd_s = 0, step, sdir, busy, pol_a, pol_b, mix_a, mix_b;
    logic [1:0] res = 0, pin = 2, sel, drv_a, drv_b;
    logic [3:0] addr = 0;
    logic [31:0] wdata = 0, rdata, d, st;
    logic [6:0] dac_a, dac_b;
    logic [5:0] pos = 6'h08;
    logic [6:0] tab [0:16] = '{7'h00, 7'h0a, 7'h14, 7'h1d, 7'h26, 7'h2f, 7'h38, 7'h3f,
        7'h47, 7'h4d, 7'h53, 7'h58, 7'h5c, 7'h60, 7'h62, 7'h64, 7'h64};
    int inc [4] = '{16, 8, 4, 1};
    int n_mismatch = 0, n_checks = 0, cyc = 0, r, k, n;
    mst_step_src u_src (.i_clk_sys(clk), .i_go(go), .i_dir(dir), .i_res(res),
        .o_step(step), .o_dir(sdir), .o_sel(sel), .o_busy(busy));
    mst_translator dut (.i_clk_sys(clk), .i_rstn(rstn), .i_step(step), .i_dir(sdir),
        .i_resolution_sel_lo(sel[0]), .i_resolution_sel_hi(sel[1]),
        .i_xlat_rst_n(xrst_n), .i_offtime_config_pin(pin), .i_thermal_trip(thermal),
        .i_overcurrent_trip(ovc), .i_cmp_a(cmp), .i_cmp_b(!cmp), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd_s), .o_rdata(rdata), .o_dac_a(dac_a),
        .o_pol_a(pol_a), .o_dac_b(dac_b), .o_pol_b(pol_b), .o_mixed_a(mix_a),
        .o_mixed_b(mix_b), .o_drv_a(drv_a), .o_drv_b(drv_b));
    initial
        forever #5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        cmp <= cyc[7:5] == 3'h7;
        if (cyc == 20000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end
    function automatic logic [15:0] lv(input logic [5:0] p);
        logic [4:0] s;
        s = p[4] ? 5'd16 - {1'b0, p[3:0]} : {1'b0, p[3:0]};
        return {p[5:4] == 2'h0 || p[5:4] == 2'h3, tab[16 - s], ~p[5], tab[s]};
    endfunction
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 q = rdata;
    endtask
    task automatic wrt(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic pulse(input logic dv, input logic [1:0] rv);
        int i;
        @(posedge clk);
        dir <= dv;
        res <= rv;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        // The model raises busy on this edge; look only once it has landed.
        @(posedge clk);
        for (i = 0; i < 500 && busy !== 1'b0; i++)
            @(posedge clk);
    endtask
    function automatic logic [1:0] drv_of(input logic b);
        return b ? drv_b : drv_a;
    endfunction
    // Length in cycles of the next fresh stay of one bridge in drive state s.
    task automatic run_len(input logic b, input logic [1:0] s, output int len);
        int i;
        for (i = 0; i < 2000 && drv_of(b) === s; i++)
            @(negedge clk);
        for (i = 0; i < 2000 && drv_of(b) !== s; i++)
            @(negedge clk);
        for (len = 0; len < 2000 && drv_of(b) === s; len++)
            @(negedge clk);
    endtask
    task automatic stpc(input logic dv, input logic [1:0] rv);
        pulse(dv, rv);
        pos = dv ? pos + 6'(inc[rv]) : pos - 6'(inc[rv]);
        rd(4'h0, st);
        chk("status", {24'h0, rv, pos}, {24'h0, st[7:0]});
        rd(4'h4, d);
        chk("levels", {16'h0, lv(pos)}, d);
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (10) @(posedge clk);
        rd(4'h4, d); chk("reset levels", 32'h0000c7c7, d);
        rd(4'h0, d); chk("reset status", 32'h00000608, d);
        rd(4'h8, d); chk("offtime", 32'h00000bb8, d);
        wrt(4'h8, 32'h00000123);
        wrt(4'h4, 32'hffffffff);
        rd(4'h8, d); chk("offtime rw", 32'h00000123, d);
        rd(4'h4, d); chk("levels ro", 32'h0000c7c7, d);
        rd(4'hc, d); chk("ctrl", 32'h0, d);
        rd(4'h2, d); chk("unmapped", 32'h0, d);
        for (r = 0; r < 4; r++)
            for (k = 0; k < 16 / inc[r]; k++)
                stpc(1'b1, r[1:0]);
        for (k = 0; k < 3; k++)
            stpc(1'b0, 2'h3);
        res <= 2'h0;
        repeat (20) @(posedge clk);
        rd(4'h0, d); chk("no early res", {24'h0, 2'h3, pos}, {24'h0, d[7:0]});
        stpc(1'b1, 2'h0);
        xrst_n <= 1'b0;
        pulse(1'b1, 2'h3);
        chk("drive off", 32'h0, {28'h0, drv_a, drv_b});
        pos = 6'h08;
        rd(4'h0, d); chk("held", 32'h108, {23'h0, d[8], 2'h0, d[5:0]});
        xrst_n <= 1'b1;
        repeat (10) @(posedge clk);
        stpc(1'b1, 2'h3);
        for (k = 0; k < 2; k++)
        begin
            {thermal, ovc} <= k ? 2'b01 : 2'b10;
            repeat (10) @(posedge clk);
            {thermal, ovc} <= 2'b00;
            repeat (10) @(posedge clk);
            pos = 6'h08;
            rd(4'h0, d); chk("trip home", 32'h8, {26'h0, d[5:0]});
        end
        pin <= 2'h0;
        repeat (20) @(posedge clk);
        stpc(1'b0, 2'h3); chk("mixed ground", 32'h3, {30'h0, st[10:9]});
        pin <= 2'h1;
        repeat (20) @(posedge clk);
        stpc(1'b1, 2'h0); chk("slow full", 32'h0, {30'h0, st[10:9]});
        pin <= 2'h2;
        repeat (20) @(posedge clk);
        stpc(1'b1, 2'h3); chk("auto decay", 32'h1, {30'h0, st[10:9]});
        // Off-time of 291 cycles: bridge A mixed gives 90 fast then 201 slow, B slow 291.
        run_len(1'b0, 2'h2, n); chk("fast part", 32'h5a, n);
        run_len(1'b0, 2'h3, n); chk("slow rest", 32'hc9, n);
        run_len(1'b1, 2'h3, n); chk("slow off", 32'h123, n);
        wrt(4'hc, 32'h00000001);
        repeat (10) @(posedge clk);
        pos = 6'h08;
        rd(4'h0, d); chk("ctrl home", 32'h8, {26'h0, d[5:0]});
        rd(4'h4, d); chk("ctrl home levels", 32'h0000c7c7, d);
        print_verdict();
    end
endmodule
